// ### hw/modem_cfg_pkg.sv
// Constants shared by both ends of the modem configuration control port.
// Assumes one clock domain at 20 MHz and 32-bit AXI4-Lite on the host side.
`default_nettype none
package modem_cfg_pkg;
  // -------------------------------------------------------------------
  // Device control port
  // -------------------------------------------------------------------
  localparam int unsigned DEV_AW = 6;                 // Device address width
  localparam int unsigned DEV_DW = 8;                 // Device data width
  localparam logic [5:0] OFS_TX_FORMAT   = 6'h0c;     // tx_format_config
  localparam logic [5:0] OFS_TEST_ROUTE  = 6'h10;     // test_output_routing
  localparam logic [5:0] OFS_FTEST_LOW   = 6'h14;     // factory_test_b_low
  localparam logic [5:0] OFS_FTEST_HIGH  = 6'h18;     // factory_test_b_high
  localparam logic [5:0] OFS_STATUS_A    = 6'h1c;     // modem_status_a
  localparam logic [7:0] CFG_RESET       = 8'h00;     // Reset of all RW registers

  // tx_format_config fields
  localparam int unsigned FLD_DIV_LO     = 3;         // Divide select, bits 4:3
  localparam int unsigned FLD_ORIGIN     = 2;         // 1 = internal preamble/header
  localparam int unsigned FLD_TX_MOD     = 1;         // 1 = DBPSK, 0 = DQPSK
  localparam int unsigned FLD_RX_MOD     = 0;         // 1 = DBPSK, 0 = DQPSK
  // modem_status_a fields
  localparam int unsigned STA_TX_READY   = 7;
  localparam int unsigned STA_CARRIER    = 4;
  localparam int unsigned STA_ENERGY     = 3;

  // Header modes
  localparam logic [1:0] HDR_MODE_0      = 2'h0;
  localparam logic [1:0] HDR_MODE_1      = 2'h1;
  localparam logic [1:0] HDR_MODE_2      = 2'h2;
  localparam logic [1:0] HDR_MODE_3      = 2'h3;

  // Preamble plus header length when built inside the device, in chips
  localparam int unsigned HDR_BITS       = 16;

  // -------------------------------------------------------------------
  // Host AXI4-Lite registers
  // -------------------------------------------------------------------
  localparam logic [3:0] HOFS_ACCESS     = 4'h0;      // Launch a device access
  localparam logic [3:0] HOFS_RESULT     = 4'h4;      // Read data and status
  localparam logic [3:0] HOFS_TXCTL      = 4'h8;      // Transmit request, data bit
  localparam int unsigned ACC_WRITE      = 16;        // ACCESS bit: 1 = write
  localparam int unsigned ACC_ADDR_LO    = 8;         // ACCESS bits 13:8 address
  localparam int unsigned RES_DONE       = 8;         // RESULT bit: read data ready
  localparam int unsigned RES_TX_READY   = 9;         // RESULT bit: tx ready seen
  localparam int unsigned TXC_REQUEST    = 0;
  localparam int unsigned TXC_BIT        = 1;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {TX_IDLE, TX_HEADER, TX_DATA} tx_state_t;

  // Divider terminal count (N - 1) for the two-bit select
  function automatic logic [3:0] div_last(input logic [1:0] sel);
    return 4'((5'h02 << sel) - 5'h01);
  endfunction
endpackage
`default_nettype wire

// ### hw/modem_ctrl_if.sv
// Interface joining the host controller and the modem configuration block.
// Assumes both ends share clk_sys; all signals are single-driver levels.
`default_nettype none
interface modem_ctrl_if;
  import modem_cfg_pkg::*;
  logic [DEV_AW-1:0] addr;       // Register offset
  logic [DEV_DW-1:0] wdata;      // Write data
  logic              wr;         // One-cycle write strobe
  logic              rd;         // One-cycle read strobe
  logic [DEV_DW-1:0] rdata;      // Read data, valid the cycle after rd
  logic              tx_request; // Level: packet in progress
  logic              ext_bit;    // External preamble/header/data bit
  logic              tx_ready;   // Device ready for packet data

  modport device (input addr, wdata, wr, rd, tx_request, ext_bit,
                  output rdata, tx_ready);
  modport host   (output addr, wdata, wr, rd, tx_request, ext_bit,
                  input rdata, tx_ready);
endinterface
`default_nettype wire

// ### hw/modem_cfg_dev.sv
// Configuration registers and transmit framing of the baseband modem.
// Assumes a host on modem_ctrl_if issuing one-cycle strobes on clk_sys,
// and header mode, lock and energy levels from the modem datapath.
`default_nettype none

// Behaviour
// R1: Transmit chip clock is master divided by 2/4/8/16
// R2: Origin bit picks internal or external header
// R3: Internal origin builds header, then raises tx ready
// R4: External origin takes header bits from host
// R5: Transmit modulation bit: one DBPSK, zero DQPSK
// R6: Ignore transmit bit in mode 0, mode 3 external
// R7: Receive modulation bit used in modes 1, 2
// R8: Routing register steers signals onto test pins
// R9: Test pins carry carrier lock and code clock
// R10: Test pin carries energy over threshold
// R11: Host programs both factory test registers zero
// R12: Status bit 7 mirrors tx ready output
// R13: Tx ready only with internal header generation
// R14: Tx ready high means host supplies data
// R15: Writes to status register are ignored
module modem_cfg_dev
  import modem_cfg_pkg::*;
(
  input  wire logic        clk_sys,          // 20 MHz master clock
  input  wire logic        reset_n,          // Asynchronous, active low
  modem_ctrl_if.device     ctl,              // Control port and transmit link
  input  wire logic [1:0]  header_mode,      // Header mode from modem setup
  input  wire logic [15:0] header_pattern,   // Programmed header settings
  input  wire logic        carrier_locked,   // Despreading code locked
  input  wire logic        energy_over,      // Signal strength over threshold
  output logic             tx_bit,           // Serial chip data to spreader
  output logic             chip_tick,        // One pulse per transmit chip
  output logic             tx_mod_dbpsk,     // Transmit modulation in use
  output logic             rx_mod_dbpsk,     // Receive modulation in use
  output logic             carrier_lock_out, // Test output seven
  output logic             energy_over_threshold, // Test output six
  output logic             test_code_clock   // Test code clock output
);

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------

  logic [7:0] tx_format_config;     // Divide, origin, modulation bits
  logic [7:0] test_output_routing;  // Zero in normal use
  logic [7:0] factory_test_b_low;   // Factory test only
  logic [7:0] factory_test_b_high;  // Factory test only

  logic [3:0] div_count;            // Chip divider counter
  logic [4:0] hdr_count;            // Header chips sent
  logic       code_clk;             // Half-rate code clock
  tx_state_t  state;                // Transmit framing state

  // -------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------

  wire logic       origin_int  = tx_format_config[FLD_ORIGIN];

  wire logic [1:0] div_sel     = tx_format_config[FLD_DIV_LO +: 2];
  wire logic       tick_now    = (div_count == div_last(div_sel));

  wire logic       route_on    = (test_output_routing != CFG_RESET);

  wire logic       hdr_done    = (hdr_count == 5'(HDR_BITS - 1));

  // Tx bit obeyed only where meaningful
  wire logic       tx_mod_used = !((header_mode == HDR_MODE_0) ||        // R6
                                   (header_mode == HDR_MODE_3 && !origin_int));
  wire logic       rx_mod_used = (header_mode == HDR_MODE_1) ||          // R7
                                 (header_mode == HDR_MODE_2);
  wire logic       ready_level = (state == TX_DATA) && origin_int;       // R13

  wire logic [7:0] status_a    = {ctl.tx_ready, 2'h0, carrier_locked,    // R12
                                  energy_over, 3'h0};

  wire logic       next_bit    = (state == TX_HEADER) ?                  // R3
                                 header_pattern[4'(HDR_BITS - 1 - hdr_count)] :
                                 ctl.ext_bit;                            // R4 R14

  // -------------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------------

  // Status is not decoded for writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_format_config    <= CFG_RESET;
      test_output_routing <= CFG_RESET;
      factory_test_b_low  <= CFG_RESET;
      factory_test_b_high <= CFG_RESET;
    end else if (ctl.wr) begin
      unique case (ctl.addr)
        OFS_TX_FORMAT:  tx_format_config    <= ctl.wdata;  // R2
        OFS_TEST_ROUTE: test_output_routing <= ctl.wdata;  // R8
        OFS_FTEST_LOW:  factory_test_b_low  <= ctl.wdata;  // R11
        OFS_FTEST_HIGH: factory_test_b_high <= ctl.wdata;  // R11
        default: ;                                         // R15
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Register reads
  // -------------------------------------------------------------------

  // Registered; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl.rdata <= CFG_RESET;
    end else if (ctl.rd) begin
      unique case (ctl.addr)
        OFS_TX_FORMAT:  ctl.rdata <= tx_format_config;
        OFS_TEST_ROUTE: ctl.rdata <= test_output_routing;
        OFS_FTEST_LOW:  ctl.rdata <= factory_test_b_low;
        OFS_FTEST_HIGH: ctl.rdata <= factory_test_b_high;
        OFS_STATUS_A:   ctl.rdata <= status_a;
        default:        ctl.rdata <= CFG_RESET;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Chip clock divider
  // -------------------------------------------------------------------

  // Select change applies at once; a count past
  // the new end runs on to 15 and wraps once
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_count <= 4'h0;
      chip_tick <= 1'b0;
      code_clk  <= 1'b0;
    end else begin
      div_count <= tick_now ? 4'h0 : div_count + 4'h1;              // R1
      chip_tick <= tick_now;                                        // R1
      code_clk  <= tick_now ? !code_clk : code_clk;
    end
  end

  // -------------------------------------------------------------------
  // Transmit framing
  // -------------------------------------------------------------------

  // Header phase only with internal origin
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state     <= TX_IDLE;
      hdr_count <= 5'h00;
    end else begin
      unique case (state)
        TX_IDLE: begin
          hdr_count <= 5'h00;
          if (ctl.tx_request) begin
            state <= origin_int ? TX_HEADER : TX_DATA;              // R2
          end
        end
        TX_HEADER: begin
          // Dropping the request aborts the header
          if (!ctl.tx_request) begin
            state <= TX_IDLE;
          end else if (tick_now) begin
            hdr_count <= hdr_count + 5'h01;
            if (hdr_done) begin
              state <= TX_DATA;                                     // R3
            end
          end
        end
        TX_DATA: begin
          if (!ctl.tx_request) begin
            state <= TX_IDLE;
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------

  // All outputs are flops
  // Status bit 7 reads the tx_ready flop itself
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl.tx_ready          <= 1'b0;
      tx_bit                <= 1'b0;
      tx_mod_dbpsk          <= 1'b1;
      rx_mod_dbpsk          <= 1'b1;
      carrier_lock_out      <= 1'b0;
      energy_over_threshold <= 1'b0;
      test_code_clock       <= 1'b0;
    end else begin
      ctl.tx_ready <= ready_level;                                  // R3 R13 R14
      tx_bit       <= (state == TX_IDLE) ? 1'b0 : next_bit;
      // Unused bits force DBPSK
      tx_mod_dbpsk <= tx_mod_used ? tx_format_config[FLD_TX_MOD] : 1'b1; // R5 R6
      rx_mod_dbpsk <= rx_mod_used ? tx_format_config[FLD_RX_MOD] : 1'b1; // R7
      // Test pins stay quiet while routing is zero
      carrier_lock_out      <= route_on && carrier_locked;          // R8 R9
      energy_over_threshold <= route_on && energy_over;             // R8 R10
      test_code_clock       <= route_on && code_clk;                // R9
    end
  end

endmodule
`default_nettype wire

// ### hw/modem_cfg_host.sv
// Host end: AXI4-Lite registers driving the modem control port.
// Assumes software waits for the done flag before the next read.
`default_nettype none
module modem_cfg_host
  import modem_cfg_pkg::*;
(
  input  wire logic        clk_sys,   // 20 MHz clock
  input  wire logic        reset_n,   // Asynchronous, active low
  modem_ctrl_if.host       ctl,       // Control port towards the device
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  logic [3:0]  aw_addr;     // Latched write address
  logic        aw_held;     // Write address taken
  logic [31:0] w_data;      // Latched write data
  logic        w_held;      // Write data taken
  logic        rd_wait;     // Device read answer due this cycle
  logic [7:0]  result;      // Last device read data
  logic        done;        // Read data fresh

  // -------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------
  wire logic aw_take  = awvalid && awready;
  wire logic w_take   = wvalid && wready;
  wire logic wr_go    = aw_held && w_held && !bvalid;
  wire logic wr_known = (aw_addr == HOFS_ACCESS) || (aw_addr == HOFS_TXCTL);
  wire logic acc_go   = wr_go && (aw_addr == HOFS_ACCESS) && wstrb[0];
  wire logic ar_take  = arvalid && arready;
  wire logic [31:0] rd_word =
    (araddr == HOFS_RESULT) ? {22'h0, ctl.tx_ready, done, result} :
    (araddr == HOFS_TXCTL)  ? {30'h0, ctl.ext_bit, ctl.tx_request} : 32'h0;
  wire logic rd_known = (araddr == HOFS_RESULT) || (araddr == HOFS_TXCTL);

  // -------------------------------------------------------------------
  // Write channels: address and data in either order
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      awready <= !aw_held && !aw_take && !bvalid;
      wready  <= !w_held && !w_take && !bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= wdata;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Device port drive
  // -------------------------------------------------------------------
  // Each access strobe lasts one cycle; read data lands two edges later
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl.addr       <= 6'h00;
      ctl.wdata      <= 8'h00;
      ctl.wr         <= 1'b0;
      ctl.rd         <= 1'b0;
      ctl.tx_request <= 1'b0;
      ctl.ext_bit    <= 1'b0;
      rd_wait        <= 1'b0;
      result         <= 8'h00;
      done           <= 1'b0;
    end else begin
      ctl.wr  <= acc_go && w_data[ACC_WRITE];
      ctl.rd  <= acc_go && !w_data[ACC_WRITE];
      rd_wait <= ctl.rd;
      if (acc_go) begin
        ctl.addr  <= w_data[ACC_ADDR_LO +: DEV_AW];
        ctl.wdata <= w_data[DEV_DW-1:0];
      end
      // Software supplies external header and data bits here
      if (wr_go && aw_addr == HOFS_TXCTL && wstrb[0]) begin        // R4 R14
        ctl.tx_request <= w_data[TXC_REQUEST];
        ctl.ext_bit    <= w_data[TXC_BIT];
      end
      // Capture wins over the clear of a newly launched read
      if (rd_wait) begin
        result <= ctl.rdata;
        done   <= 1'b1;
      end else if (acc_go) begin
        done <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Read channels
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !ar_take;
      if (ar_take) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/modem_cfg_checker.sv
// Checker for the control port between host end and device end.
// Assumes the testbench instantiates it beside modem_ctrl_if.
`default_nettype none
module modem_cfg_checker
  import modem_cfg_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic [DEV_AW-1:0] addr,
  input  wire logic [DEV_DW-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  input  wire logic [DEV_DW-1:0] rdata,
  input  wire logic              tx_request,
  input  wire logic              tx_ready
);
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  logic [7:0] fmt, route, ft_lo, ft_hi;             // Last written values
  wire logic [7:0] exp_rd = (addr == OFS_TX_FORMAT)  ? fmt   :
                            (addr == OFS_TEST_ROUTE) ? route :
                            (addr == OFS_FTEST_LOW)  ? ft_lo :
                            (addr == OFS_FTEST_HIGH) ? ft_hi : 8'h00;
  wire logic       origin = fmt[FLD_ORIGIN];        // Internal header chosen

  // Shadow each write; status writes leave none
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) {fmt, route, ft_lo, ft_hi} <= 32'h0;
    else if (wr && addr == OFS_TX_FORMAT) fmt <= wdata;
    else if (wr && addr == OFS_TEST_ROUTE) route <= wdata;
    else if (wr && addr == OFS_FTEST_LOW) ft_lo <= wdata;
    else if (wr && addr == OFS_FTEST_HIGH) ft_hi <= wdata;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence quiet_s; !tx_ready [*8]; endsequence      // Header still running
  sequence ready_s; ##[1:700] tx_ready; endsequence  // Longest header at N=16

  read_back_a: assert property (rd && addr != OFS_STATUS_A |=> rdata == $past(exp_rd))
    else $error("read back wrong");
  status_ready_a: assert property (rd && addr == OFS_STATUS_A |=>
    rdata[STA_TX_READY] == $past(tx_ready)) else $error("status bit 7 wrong");
  ready_origin_a: assert property ($rose(tx_ready) |-> origin && tx_request)
    else $error("ready without origin");
  header_first_a: assert property ($rose(tx_request) |-> quiet_s)
    else $error("ready too early");
  ready_bound_a: assert property ($rose(tx_request) && origin |-> ready_s)
    else $error("tx ready never came");
  ext_quiet_a: assert property (tx_request && !origin |-> !tx_ready)
    else $error("ready in external mode");
  ready_drop_a: assert property (!tx_request [*3] |-> !tx_ready)
    else $error("ready stuck");
  rdata_hold_a: assert property (!rd |=> $stable(rdata))
    else $error("rdata moved");
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Testbench: host end and device end joined by modem_ctrl_if.
// Assumes the package, interface, both ends and the checker come first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import modem_cfg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0, reset_n = 1'b0;     // Clock, reset
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, header_mode = 2'h0;
  logic        carrier_locked = 1'b0, energy_over = 1'b0;
  logic        tx_bit, chip_tick, tx_mod_dbpsk, rx_mod_dbpsk;
  logic        carrier_lock_out, energy_over_threshold, test_code_clock;
  int          fails = 0, checks = 0;              // Mismatches, comparisons
  logic [5:0]  ofs [4] = '{OFS_TX_FORMAT, OFS_TEST_ROUTE, OFS_FTEST_LOW, OFS_FTEST_HIGH};

  modem_ctrl_if ctl ();
  modem_cfg_host i_modem_cfg_host (.clk_sys(clk_sys), .reset_n(reset_n), .ctl(ctl),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  // Header pattern tied; header bits unchecked
  modem_cfg_dev i_modem_cfg_dev (.clk_sys(clk_sys), .reset_n(reset_n), .ctl(ctl),
    .header_mode(header_mode), .header_pattern(16'ha5c3), .carrier_locked(carrier_locked),
    .energy_over(energy_over), .tx_bit(tx_bit), .chip_tick(chip_tick),
    .tx_mod_dbpsk(tx_mod_dbpsk), .rx_mod_dbpsk(rx_mod_dbpsk),
    .carrier_lock_out(carrier_lock_out), .energy_over_threshold(energy_over_threshold),
    .test_code_clock(test_code_clock));
  modem_cfg_checker i_modem_cfg_checker (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr(ctl.addr), .wdata(ctl.wdata), .wr(ctl.wr), .rd(ctl.rd), .rdata(ctl.rdata),
    .tx_request(ctl.tx_request), .tx_ready(ctl.tx_ready));

  // 20 MHz clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic lost();
    fails++;
    $display("FAIL %0t wait ran out", $time);
    close_out();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Ready sampled mid-cycle for the next edge
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic [2:0] s = 3'b000;
    int n = 0;
    @(posedge clk_sys);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!s[0]) begin
      @(negedge clk_sys);
      s = {awready, wready, bvalid};
      if (++n > 50) lost();
      @(posedge clk_sys);
      if (s[2]) awvalid <= 1'b0;
      if (s[1]) wvalid <= 1'b0;
      if (s[0]) bready <= 1'b0;
    end
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic [1:0] s = 2'b00;
    int n = 0;
    @(posedge clk_sys);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!s[0]) begin
      @(negedge clk_sys);
      s = {arready, rvalid};
      {d, r} = {rdata, rresp};
      if (++n > 50) lost();
      @(posedge clk_sys);
      if (s[1]) arvalid <= 1'b0;
      if (s[0]) rready <= 1'b0;
    end
  endtask
  task automatic dev_write(input logic [5:0] a, input logic [7:0] d);
    axi_write(HOFS_ACCESS, (32'h1 << ACC_WRITE) | (32'(a) << ACC_ADDR_LO) | 32'(d));
  endtask
  // Poll done; a hung read ends the run
  task automatic dev_read(input logic [5:0] a, output logic [7:0] d);
    logic [31:0] v = 32'h0;
    logic [1:0] r;
    int n = 0;
    axi_write(HOFS_ACCESS, 32'(a) << ACC_ADDR_LO);
    while (v[RES_DONE] !== 1'b1) begin
      axi_read(HOFS_RESULT, v, r);
      if (++n > 20) lost();
    end
    d = v[7:0];
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [7:0] d;
    int n;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Reset, write, read back, then zero
    for (int i = 0; i < 4; i++) begin
      dev_read(ofs[i], d);
      chk(d, CFG_RESET, "reset value");
      dev_write(ofs[i], 8'h5a ^ 8'(i));
      dev_read(ofs[i], d);
      chk(d, 8'h5a ^ 8'(i), "read back");
      dev_write(ofs[i], 8'h00);
    end
    dev_read(OFS_FTEST_HIGH, d);
    chk(d, 8'h00, "factory zero");
    dev_read(6'h20, d);
    chk(d, 8'h00, "unmapped device read");
    axi_read(4'hc, v, r);
    chk(r, RESP_SLVERR, "unmapped host read");
    // Status is read only and shows live levels
    carrier_locked <= 1'b1;
    dev_write(OFS_STATUS_A, 8'hff);
    dev_read(OFS_STATUS_A, d);
    chk({d[7], d[4:3]}, 3'b010, "status");
    // Header modes against modulation bits
    for (int i = 0; i < 32; i++) begin
      header_mode <= 2'(i >> 3);
      dev_write(OFS_TX_FORMAT, 8'(i & 7));
      repeat (3) @(negedge clk_sys);
      v[0] = (i < 8 || (i >= 24 && i[2] == 1'b0)) ? 1'b1 : i[1];
      v[1] = (i >= 8 && i < 24) ? i[0] : 1'b1;
      chk(tx_mod_dbpsk, v[0], "tx modulation");
      chk(rx_mod_dbpsk, v[1], "rx modulation");
    end
    // Chip divider per select, after settling
    for (int s = 0; s < 4; s++) begin
      dev_write(OFS_TX_FORMAT, 8'(s << FLD_DIV_LO));
      repeat (3) begin
        n = 0;
        do begin
          @(negedge clk_sys);
          n++;
        end while (chip_tick !== 1'b1 && n < 40);
      end
      chk(n, 2 << s, "chip divider");
    end
    // Test pins dark at zero routing, live otherwise
    energy_over <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({carrier_lock_out, energy_over_threshold, test_code_clock}, 3'b000, "routing off");
    dev_write(OFS_TEST_ROUTE, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk({carrier_lock_out, energy_over_threshold}, 2'b11, "test pins");
    v[0] = test_code_clock;
    repeat (16) @(negedge clk_sys);
    chk(test_code_clock, !v[0], "code clock");
    carrier_locked <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({carrier_lock_out, energy_over_threshold}, 2'b01, "energy pin");
    dev_write(OFS_TEST_ROUTE, 8'h00);
    // Internal header: ready, mirrored in status
    dev_write(OFS_TX_FORMAT, 8'h04);
    axi_write(HOFS_TXCTL, 32'h1);
    n = 0;
    do begin
      axi_read(HOFS_RESULT, v, r);
      n++;
    end while (v[RES_TX_READY] !== 1'b1 && n < 100);
    chk(v[RES_TX_READY], 1'b1, "tx ready");
    dev_read(OFS_STATUS_A, d);
    chk(d[STA_TX_READY], 1'b1, "status ready");
    axi_write(HOFS_TXCTL, 32'h0);
    repeat (4) @(posedge clk_sys);
    axi_read(HOFS_RESULT, v, r);
    chk(v[RES_TX_READY], 1'b0, "ready dropped");
    // External header: host bit passes, no ready
    dev_write(OFS_TX_FORMAT, 8'h00);
    axi_write(HOFS_TXCTL, 32'h3);
    repeat (80) @(negedge clk_sys);
    chk({tx_bit, ctl.tx_ready}, 2'b10, "external header");
    axi_write(HOFS_TXCTL, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
